//--- logic/tfio_pin_drv.v
// per-bit pad control: output select, push-pull or open-drain enable, pull-up
// assumes registered controls from the same clock
module tfio_pin_drv
#(
   parameter W = 2
)
(
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] dir,
   input  wire [W-1:0] otype,
   input  wire [W-1:0] fsel,
   input  wire [W-1:0] latch,
   input  wire [W-1:0] alt,
   input  wire [W-1:0] pu,
   output reg  [W-1:0] pin_o,
   output reg  [W-1:0] pin_oe,
   output reg  [W-1:0] pu_on
);
   wire [W-1:0] value = (fsel & alt) | (~fsel & latch);

   always @(posedge clk)
   begin
      if (rst)
      begin
         pin_o  <= {W{1'b0}};
         pin_oe <= {W{1'b0}};
         pu_on  <= {W{1'b0}};
      end
      else
      begin
         // open-drain releases the pin for a one
         pin_o  <= value & ~otype; // R7 R17
         pin_oe <= dir & (~otype | ~value); // R3 R17
         pu_on  <= pu & (~dir | otype); // R4
      end
   end
endmodule

//--- logic/tfio_sync.v
// two-flop synchroniser for a bus of pin levels
// assumes inputs are asynchronous to clk
module tfio_sync
#(
   parameter W = 2
)
(
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] stage;

   always @(posedge clk)
   begin
      if (rst)
      begin
         stage <= {W{1'b0}};
         dout  <= {W{1'b0}};
      end
      else
      begin
         stage <= din;
         dout  <= stage;
      end
   end
endmodule

//--- logic/tfio_top.v
// avalon-mm register block and pin logic of the timer, uart and serial ports
// assumes pins and alternate-function levels are asynchronous; one 20 MHz clock
// What this block does
// R1: timer pin read: level if input, else 0
// R2: uart port has two independent direction bits
// R3: uart output type: 0 push-pull, 1 open-drain
// R4: pull-up only when enabled and input or open-drain
// R5: pull-up control 0 disconnects; resets to 0
// R6: uart pin read masks push-pull outputs to 0
// R7: uart latch drives pin level; upper bits zero
// R8: uart direction 0 input with receive, 1 output
// R9: uart function select picks latch or transmit
// R10: software also programs serial pin selection
// R11: serial port bits 7..4 with independent direction
// R12: software also configures serial pin selection
// R13: serial latch bits 7..4, low bits zero
// R14: serial direction resets 0; 1 means output
// R15: serial output type resets 0; 1 open-drain
// R16: serial pin read masks push-pull outputs to 0
// R17: open-drain one releases the pin
//
// Added by the designer: the Avalon-MM slave port.
`include "tfio_map.vh"
module tfio_top
(
   input  wire        CLK_SYS,
   input  wire        SYS_RST,
   input  wire [11:0] AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [31:0] AVS_WRITEDATA,
   output reg  [31:0] AVS_READDATA,
   output reg         AVS_WAITREQUEST,
   input  wire [1:0]  TIMER_PIN_I,
   input  wire [1:0]  UART_PIN_I,
   output wire [1:0]  UART_PIN_O,
   output wire [1:0]  UART_PIN_OE,
   output wire [1:0]  UART_PULLUP_ON,
   input  wire [3:0]  SERIAL_PIN_I,
   output wire [3:0]  SERIAL_PIN_O,
   output wire [3:0]  SERIAL_PIN_OE,
   input  wire [1:0]  SECOND_UART_TRANSMIT,
   output reg  [1:0]  SECOND_UART_RECEIVE,
   input  wire        SYNC_SERIAL_CLOCK,
   input  wire        SYNC_SERIAL_OUT,
   input  wire        FIRST_UART_TRANSMIT,
   output reg  [3:0]  SERIAL_PIN_LEVEL
);
   reg  [1:0] timer_port_direction;
   reg  [1:0] uart_port_output_latch;
   reg  [1:0] uart_port_direction;
   reg  [1:0] uart_port_function_select;
   reg  [1:0] uart_port_output_type;
   reg  [1:0] uart_port_pullup_enable;
   reg  [3:0] serial_port_output_latch;
   reg  [3:0] serial_port_direction;
   reg  [3:0] serial_port_output_type;
   reg  [2:0] serial_port_function_select;
   wire [1:0] timer_sync;
   wire [1:0] uart_sync;
   wire [3:0] serial_sync;
   wire [2:0] alt_sync;
   wire [1:0] uart_tx_sync;
   wire [3:0] serial_alt;
   reg  [31:0] next_readdata;
   wire       access;

   // masked pin read: level when input or open-drain, else 0
   function [3:0] pin_read;
      input [3:0] level;
      input [3:0] dir;
      input [3:0] otype;
      begin
         pin_read = level & (~dir | otype);
      end
   endfunction

   tfio_sync #(.W(2)) u_sync_timer
   (
      .clk  (CLK_SYS),
      .rst  (SYS_RST),
      .din  (TIMER_PIN_I),
      .dout (timer_sync)
   );

   tfio_sync #(.W(2)) u_sync_uart
   (
      .clk  (CLK_SYS),
      .rst  (SYS_RST),
      .din  (UART_PIN_I),
      .dout (uart_sync)
   );

   tfio_sync #(.W(4)) u_sync_serial
   (
      .clk  (CLK_SYS),
      .rst  (SYS_RST),
      .din  (SERIAL_PIN_I),
      .dout (serial_sync)
   );

   tfio_sync #(.W(5)) u_sync_alt
   (
      .clk  (CLK_SYS),
      .rst  (SYS_RST),
      .din  ({SECOND_UART_TRANSMIT, SYNC_SERIAL_CLOCK, FIRST_UART_TRANSMIT,
              SYNC_SERIAL_OUT}),
      .dout ({uart_tx_sync, alt_sync})
   );

   // bit 6 serial clock, bit 5 uart transmit, bit 4 transmit or serial out
   assign serial_alt = {1'b0, alt_sync[2], alt_sync[1], alt_sync[1] | alt_sync[0]};

   tfio_pin_drv #(.W(2)) u_drv_uart
   (
      .clk    (CLK_SYS),
      .rst    (SYS_RST),
      .dir    (uart_port_direction), // R2 R8
      .otype  (uart_port_output_type), // R3 R17
      .fsel   (uart_port_function_select), // R9
      .latch  (uart_port_output_latch), // R7
      .alt    (uart_tx_sync),
      .pu     (uart_port_pullup_enable), // R4 R5
      .pin_o  (UART_PIN_O),
      .pin_oe (UART_PIN_OE),
      .pu_on  (UART_PULLUP_ON)
   );

   tfio_pin_drv #(.W(4)) u_drv_serial
   (
      .clk    (CLK_SYS),
      .rst    (SYS_RST),
      .dir    (serial_port_direction), // R11 R14
      .otype  (serial_port_output_type), // R15 R17
      .fsel   ({1'b0, serial_port_function_select}),
      .latch  (serial_port_output_latch), // R13
      .alt    (serial_alt),
      .pu     (4'h0),
      .pin_o  (SERIAL_PIN_O),
      .pin_oe (SERIAL_PIN_OE),
      .pu_on  ()
   );

   assign access = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;

   // register writes, one cycle after request with waitrequest released
   always @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         timer_port_direction        <= `TFIO_RST_2BIT;
         uart_port_output_latch      <= `TFIO_RST_2BIT;
         uart_port_direction         <= `TFIO_RST_2BIT;
         uart_port_function_select   <= `TFIO_RST_2BIT;
         uart_port_output_type       <= `TFIO_RST_2BIT;
         uart_port_pullup_enable     <= `TFIO_RST_2BIT;
         serial_port_output_latch    <= `TFIO_RST_4BIT;
         serial_port_direction       <= `TFIO_RST_4BIT;
         serial_port_output_type     <= `TFIO_RST_4BIT;
         serial_port_function_select <= 3'h0;
      end
      else if (AVS_WRITE && !AVS_WAITREQUEST)
      begin
         if (AVS_ADDRESS == `TFIO_OFS_UART_OUT)
            uart_port_output_latch <= AVS_WRITEDATA[1:0]; // R7
         else if (AVS_ADDRESS == `TFIO_OFS_SER_OUT)
            serial_port_output_latch <= AVS_WRITEDATA[`TFIO_SER_MSB:`TFIO_SER_LSB]; // R13
         else if (AVS_ADDRESS == `TFIO_OFS_TMR_DIR)
            timer_port_direction <= AVS_WRITEDATA[1:0];
         else if (AVS_ADDRESS == `TFIO_OFS_UART_DIR)
            uart_port_direction <= AVS_WRITEDATA[1:0]; // R2 R8
         else if (AVS_ADDRESS == `TFIO_OFS_SER_DIR)
            serial_port_direction <= AVS_WRITEDATA[`TFIO_SER_MSB:`TFIO_SER_LSB]; // R14
         else if (AVS_ADDRESS == `TFIO_OFS_UART_PU)
            uart_port_pullup_enable <= AVS_WRITEDATA[1:0]; // R5
         else if (AVS_ADDRESS == `TFIO_OFS_UART_FSEL)
            uart_port_function_select <= AVS_WRITEDATA[1:0]; // R9
         else if (AVS_ADDRESS == `TFIO_OFS_SER_FSEL)
            serial_port_function_select <= AVS_WRITEDATA[`TFIO_SER_FSEL_MSB:`TFIO_SER_LSB];
         else if (AVS_ADDRESS == `TFIO_OFS_UART_OTYPE)
            uart_port_output_type <= AVS_WRITEDATA[1:0]; // R3
         else if (AVS_ADDRESS == `TFIO_OFS_SER_OTYPE)
            serial_port_output_type <= AVS_WRITEDATA[`TFIO_SER_MSB:`TFIO_SER_LSB]; // R15
      end
   end

   // read mux; unmapped addresses read zero
   always @*
   begin
      next_readdata = 32'h0000_0000;
      if (AVS_ADDRESS == `TFIO_OFS_UART_OUT)
         next_readdata[1:0] = uart_port_output_latch; // R7
      else if (AVS_ADDRESS == `TFIO_OFS_SER_OUT)
         next_readdata[7:4] = serial_port_output_latch; // R13
      else if (AVS_ADDRESS == `TFIO_OFS_TMR_PIN)
         next_readdata[1:0] = timer_sync & ~timer_port_direction; // R1
      else if (AVS_ADDRESS == `TFIO_OFS_UART_PIN)
         next_readdata[3:0] = pin_read({2'h0, uart_sync}, {2'h0, uart_port_direction},
                                       {2'h0, uart_port_output_type}); // R6
      else if (AVS_ADDRESS == `TFIO_OFS_SER_PIN)
         next_readdata[7:4] = pin_read(serial_sync, serial_port_direction,
                                       serial_port_output_type); // R16
      else if (AVS_ADDRESS == `TFIO_OFS_TMR_DIR)
         next_readdata[1:0] = timer_port_direction;
      else if (AVS_ADDRESS == `TFIO_OFS_UART_DIR)
         next_readdata[1:0] = uart_port_direction;
      else if (AVS_ADDRESS == `TFIO_OFS_SER_DIR)
         next_readdata[7:4] = serial_port_direction;
      else if (AVS_ADDRESS == `TFIO_OFS_UART_PU)
         next_readdata[1:0] = uart_port_pullup_enable;
      else if (AVS_ADDRESS == `TFIO_OFS_UART_FSEL)
         next_readdata[1:0] = uart_port_function_select;
      else if (AVS_ADDRESS == `TFIO_OFS_SER_FSEL)
         next_readdata[6:4] = serial_port_function_select;
      else if (AVS_ADDRESS == `TFIO_OFS_UART_OTYPE)
         next_readdata[1:0] = uart_port_output_type;
      else if (AVS_ADDRESS == `TFIO_OFS_SER_OTYPE)
         next_readdata[7:4] = serial_port_output_type;
   end

   // waitrequest drops for one cycle per request; read data valid then
   always @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         AVS_WAITREQUEST     <= 1'b1;
         AVS_READDATA        <= 32'h0000_0000;
         SECOND_UART_RECEIVE <= 2'h0;
         SERIAL_PIN_LEVEL    <= 4'h0;
      end
      else
      begin
         AVS_WAITREQUEST <= ~access;
         if (access && AVS_READ)
            AVS_READDATA <= next_readdata;
         // receive inputs follow the pin whenever the bit is an input
         SECOND_UART_RECEIVE <= uart_sync & ~uart_port_direction; // R8
         SERIAL_PIN_LEVEL    <= serial_sync & ~serial_port_direction;
      end
   end
endmodule

//--- shared/tfio_map.vh
// register offsets, field positions and reset values of the small i/o ports
// assumes word-addressed avalon-mm slave with 12-bit address
`ifndef TFIO_MAP_VH
`define TFIO_MAP_VH
`define TFIO_OFS_UART_OUT     12'h009
`define TFIO_OFS_SER_OUT      12'h00b
`define TFIO_OFS_TMR_PIN      12'h015
`define TFIO_OFS_UART_PIN     12'h016
`define TFIO_OFS_SER_PIN      12'h018
`define TFIO_OFS_TMR_DIR      12'hf22
`define TFIO_OFS_UART_DIR     12'hf23
`define TFIO_OFS_SER_DIR      12'hf25
`define TFIO_OFS_UART_PU      12'hf30
`define TFIO_OFS_UART_FSEL    12'hf3d
`define TFIO_OFS_SER_FSEL     12'hf3f
`define TFIO_OFS_UART_OTYPE   12'hf4a
`define TFIO_OFS_SER_OTYPE    12'hf4c
`define TFIO_RST_2BIT         2'h0
`define TFIO_RST_4BIT         4'h0
`define TFIO_SER_LSB          4
`define TFIO_SER_MSB          7
`define TFIO_SER_FSEL_MSB     6
`endif

//--- sim/tfio_monitor.sv
// checker of the small i/o ports: bus handshake, pull-up and reset relations
// assumes it is bound to tfio_top and sees only its ports
module tfio_monitor
(
   input wire logic        CLK_SYS,
   input wire logic        SYS_RST,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic [1:0]  UART_PIN_O,
   input wire logic [1:0]  UART_PIN_OE,
   input wire logic [1:0]  UART_PULLUP_ON,
   input wire logic [3:0]  SERIAL_PIN_OE,
   input wire logic [1:0]  SECOND_UART_RECEIVE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST) else $error("request not answered");
   chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low too long");
   chk_idle_wait: assert property (!(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> AVS_WAITREQUEST) else $error("answer without request");
   chk_reset_vals: assert property ($fell(SYS_RST) |-> AVS_WAITREQUEST
      && UART_PIN_OE == 2'h0 && SERIAL_PIN_OE == 4'h0 && UART_PULLUP_ON == 2'h0)
      else $error("outputs not cleared by reset");
   chk_od_low: assert property (
      (UART_PULLUP_ON & UART_PIN_OE & UART_PIN_O) == 2'h0)
      else $error("pad drives high while pull-up on");
   chk_data_hold: assert property (!(AVS_READ && AVS_WAITREQUEST)
      |=> $stable(AVS_READDATA)) else $error("read data changed without read");
   chk_pu_static: assert property (
      (!AVS_WRITE || AVS_WAITREQUEST) [*2] |=> $stable(UART_PULLUP_ON))
      else $error("pull-up changed without write");
   chk_rx_masked: assert property (UART_PIN_OE[0] [*3] |-> !SECOND_UART_RECEIVE[0])
      else $error("receive not masked on output bit");
endmodule

bind tfio_top tfio_monitor mon (.CLK_SYS, .SYS_RST, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
   .AVS_WAITREQUEST, .UART_PIN_O, .UART_PIN_OE, .UART_PULLUP_ON, .SERIAL_PIN_OE,
   .SECOND_UART_RECEIVE);

//--- sim/tfio_top_test.sv
// self-checking bench of the small i/o ports over avalon-mm
// assumes the monitor binds itself to the dut
module tfio_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        CLK_SYS = 0;
   logic        SYS_RST = 1;
   logic [11:0] AVS_ADDRESS = 0;
   logic        AVS_READ = 0;
   logic        AVS_WRITE = 0;
   logic [31:0] AVS_WRITEDATA = 0;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST;
   logic [1:0]  TIMER_PIN_I = 0;
   logic [1:0]  UART_PIN_I, UART_PIN_O, UART_PIN_OE, UART_PULLUP_ON;
   logic [3:0]  SERIAL_PIN_I, SERIAL_PIN_O, SERIAL_PIN_OE, SERIAL_PIN_LEVEL;
   logic [1:0]  SECOND_UART_TRANSMIT = 0;
   logic [1:0]  SECOND_UART_RECEIVE;
   logic        SYNC_SERIAL_CLOCK = 0;
   logic        SYNC_SERIAL_OUT = 0;
   logic        FIRST_UART_TRANSMIT = 0;
   logic [1:0]  ext_u = 0;
   logic [3:0]  ext_s = 0;
   logic [31:0] r;
   logic [3:0]  sf, sv, sl;
   logic [31:0] exp_q[$];
   int          mismatches = 0;
   int          tests_run = 0;
   int          seed = 32'h27a8;
   logic [11:0] ofs[11] = '{12'h009, 12'h00b, 12'hf22, 12'hf23, 12'hf25, 12'hf30,
                           12'hf3d, 12'hf3f, 12'hf4a, 12'hf4c, 12'h100};
   logic [7:0]  msk[11] = '{8'h03, 8'hf0, 8'h03, 8'h03, 8'hf0, 8'h03,
                           8'h03, 8'h70, 8'h03, 8'hf0, 8'h00};

   // wire level: a driving pad forces it, else the outside world does
   assign UART_PIN_I = (UART_PIN_OE & UART_PIN_O) | (~UART_PIN_OE & ext_u);
   assign SERIAL_PIN_I = (SERIAL_PIN_OE & SERIAL_PIN_O) | (~SERIAL_PIN_OE & ext_s);

   tfio_top dut (.CLK_SYS, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
      .AVS_READDATA, .AVS_WAITREQUEST, .TIMER_PIN_I, .UART_PIN_I, .UART_PIN_O,
      .UART_PIN_OE, .UART_PULLUP_ON, .SERIAL_PIN_I, .SERIAL_PIN_O, .SERIAL_PIN_OE,
      .SECOND_UART_TRANSMIT, .SECOND_UART_RECEIVE, .SYNC_SERIAL_CLOCK,
      .SYNC_SERIAL_OUT, .FIRST_UART_TRANSMIT, .SERIAL_PIN_LEVEL);

   initial forever #25 CLK_SYS = ~CLK_SYS;

   task automatic check(input logic [31:0] s, e);
      tests_run++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, e);
      if (!w)
         exp_q.push_back(e);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      @(posedge CLK_SYS);
      while (AVS_WAITREQUEST !== 1'b0)
         @(posedge CLK_SYS);
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      @(posedge CLK_SYS);
   endtask

   task automatic pins(input logic [7:0] e);
      repeat (4) @(posedge CLK_SYS);
      check(32'({UART_PULLUP_ON, UART_PIN_OE, UART_PIN_O & UART_PIN_OE,
                 SECOND_UART_RECEIVE}), 32'(e));
   endtask

   task automatic wrap_up;
      if (mismatches == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge CLK_SYS)
      if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0)
         check(AVS_READDATA, exp_q.pop_front());

   initial
   begin
      repeat (20000) @(posedge CLK_SYS);
      mismatches++;
      wrap_up();
   end

   initial
   begin
      repeat (20) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      @(posedge CLK_SYS);
      foreach (ofs[i]) bus(1'b0, ofs[i], 0, 0);
      foreach (ofs[i])
      begin
         bus(1'b1, ofs[i], 32'hffff_ffff, 0);
         bus(1'b0, ofs[i], 0, 32'(msk[i]));
      end
      foreach (ofs[i]) bus(1'b1, ofs[i], 0, 0);
      ext_u <= 2'h2;
      bus(1'b1, 12'h009, 32'h0000_0002, 0);
      bus(1'b1, 12'hf30, 32'h0000_0003, 0);
      bus(1'b1, 12'hf23, 32'h0000_0003, 0);
      pins(8'h38);
      bus(1'b1, 12'hf4a, 32'h0000_0003, 0);
      pins(8'hd0);
      bus(1'b1, 12'hf23, 0, 0);
      pins(8'hc2);
      SECOND_UART_TRANSMIT <= 2'h1;
      bus(1'b1, 12'hf4a, 0, 0);
      bus(1'b1, 12'hf3d, 32'h0000_0003, 0);
      bus(1'b1, 12'hf23, 32'h0000_0003, 0);
      pins(8'h34);
      bus(1'b1, 12'hf25, 32'h0000_00f0, 0);
      bus(1'b1, 12'h00b, 32'h0000_00a0, 0);
      repeat (4) @(posedge CLK_SYS);
      check(32'({SERIAL_PIN_OE, SERIAL_PIN_O}), 32'h0000_00fa);
      bus(1'b1, 12'hf3d, 0, 0);
      bus(1'b1, 12'h009, 32'h0000_0003, 0);
      bus(1'b1, 12'h00b, 32'h0000_00f0, 0);
      repeat (20)
      begin
         r = $random(seed);
         // serial pin value: alternate level where selected, else the all-ones latch
         sf = {1'b0, r[29:27]};
         sv = (sf & {1'b0, r[24], r[22], r[22] | r[23]}) | (~sf & 4'hf);
         // wire level: push-pull drives, open-drain only pulls low, input follows outside
         sl = (r[17:14] & ~r[21:18] & sv) | (r[17:14] & r[21:18] & sv & r[5:2])
              | (~r[17:14] & r[5:2]);
         ext_u <= r[1:0];
         ext_s <= r[5:2];
         TIMER_PIN_I <= r[7:6];
         {SYNC_SERIAL_CLOCK, SYNC_SERIAL_OUT, FIRST_UART_TRANSMIT} <= r[24:22];
         SECOND_UART_TRANSMIT <= r[26:25];
         bus(1'b1, 12'hf22, 32'(r[9:8]), 0);
         bus(1'b1, 12'hf23, 32'(r[11:10]), 0);
         bus(1'b1, 12'hf4a, 32'(r[13:12]), 0);
         bus(1'b1, 12'hf25, 32'({r[17:14], 4'h0}), 0);
         bus(1'b1, 12'hf4c, 32'({r[21:18], 4'h0}), 0);
         bus(1'b1, 12'hf3f, 32'({r[29:27], 4'h0}), 0);
         repeat (4) @(posedge CLK_SYS);
         check(32'(SERIAL_PIN_I), 32'(sl));
         check(32'(SERIAL_PIN_LEVEL), 32'(r[5:2] & ~r[17:14]));
         bus(1'b0, 12'h015, 0, 32'(r[7:6] & ~r[9:8]));
         bus(1'b0, 12'h016, 0, 32'(r[1:0] & (~r[11:10] | r[13:12])));
         bus(1'b0, 12'h018, 0, 32'({sl & (~r[17:14] | r[21:18]), 4'h0}));
      end
      repeat (2) @(posedge CLK_SYS);
      wrap_up();
   end
endmodule
